// >>> pwmt_event_fault.sv
// What this block does
// - event action 0 gives fault only, 1 gives fault plus capture.
// - trigger enable in event control A routes the event to input A.
// - trigger enable in event control B routes the event to input B.
// - filter mode needs four equal samples before the level changes.
// - code 2 acts directly, code 0 plain sampling, code 3 reserved.
// - edge bit 0 selects falling/low, 1 selects rising/high.
// - interrupt enable bits 3 and 2 request on trigger B and A.
// - interrupt enable bit 0 requests on restart or overflow.
// - flag bit 3 sets on trigger B or capture B.
// - flag bit 2 sets on trigger A or capture A.
// - flag bit 0 sets at the end of every timer cycle.
// - flags clear only by writing one; zero leaves them.
// - status bits 7 and 6 set on any change of output B and A.
// - activity bits stay set until software writes one.
// - command ready drops on command strobes or auto-update write.
// - enable ready drops on enable write or disable-at-end strobe.
// - enable ready also drops in debug break without debug run.
// - input A modes 1 to 3 act on its own output; mode 0 does nothing.
// - modes 4 to 7 stop all outputs, each with its release.
// - modes 8 to A stop the own output by edge or level.
// - strobes written while a command is in flight are ignored.
// - input B has its own mode field with the same coding.
// - a stopped output with fault enable shows its fault value.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pwmt_event_fault
    import pwmt_pkg::*;
#(
    parameter logic [15:0] PERIOD = 16'h0100
)(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        event_a_in,
    input  wire logic        event_b_in,
    input  wire logic        debug_break,
    output logic             wave_out_a,
    output logic             wave_out_b,
    output logic             irq_out,
    output logic      [15:0] capture_a,
    output logic      [15:0] capture_b
);
    localparam logic [15:0] HALF = PERIOD >> 1;

    function automatic logic wr_at(input logic wr, input logic [5:0] idx, input logic [5:0] k);
        wr_at = wr && (idx == k);
    endfunction

    logic              ack_q;
    logic        [7:0] ev_a_q, ev_b_q, int_en_q, flags_q, mode_a_q, mode_b_q, fault_q;
    logic              ctrl_en_q, auto_upd_q, debug_run_q;
    logic        [1:0] act_q;
    logic              cmd_ready_q, en_ready_q, eoc_wait_q, dis_wait_q;
    logic        [4:0] cmd_bits_q;
    logic              en_val_q, en_dis_q, timer_en_q, brk_q;
    logic [SYNC_STAGES-1:0] cmd_pipe_q, en_pipe_q;
    logic       [15:0] cnt_q;

    // bus decode; writes land at the edge where ack is seen high
    wire       req      = wb_cyc_i & wb_stb_i;
    wire       wr       = req & wb_we_i & ack_q & wb_sel_i[0];
    wire [5:0] idx      = wb_adr_i[7:2];
    wire [7:0] wd       = wb_dat_i[7:0];
    wire       wr_cmd   = wr_at(wr, idx, IDX_COMMAND);
    wire       wr_control_a = wr_at(wr, idx, IDX_CONTROL_A);
    wire       wr_clrh  = wr_at(wr, idx, IDX_CMPB_CLRH);

    // command handshake
    wire cmd_req   = (wr_cmd & (|wd[4:0])) | (wr_clrh & auto_upd_q);
    wire cmd_start = cmd_req & cmd_ready_q;
    wire cmd_land  = cmd_pipe_q[SYNC_STAGES-1];
    wire restart   = cmd_land & cmd_bits_q[CMD_RESTART];
    wire soft_a    = cmd_land & cmd_bits_q[CMD_CAPT_A];
    wire soft_b    = cmd_land & cmd_bits_q[CMD_CAPT_B];
    wire brk       = debug_break & ~debug_run_q;
    wire en_req    = wr_control_a | (wr_cmd & wd[CMD_DIS_EOC]);
    wire en_start  = en_req & en_ready_q & ~brk;
    wire en_land   = en_pipe_q[SYNC_STAGES-1];

    // timer base
    wire run       = timer_en_q & ~brk;
    wire cycle_end = run & (cnt_q == PERIOD - 16'h0001);
    wire base_a    = run & (cnt_q < HALF);
    wire base_b    = run & ~(cnt_q < HALF);

    // per-input qualification and fault hold
    logic [1:0]      ev_in, hit, own_stop, all_stop, jump, trig_set;
    logic [1:0][7:0] evc, mode;
    assign ev_in    = {event_b_in, event_a_in};
    assign evc      = {ev_b_q, ev_a_q};
    assign mode     = {mode_b_q, mode_a_q};
    assign trig_set = hit | {soft_b, soft_a};

    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_in
            logic [FILTER_SAMPLES-2:0] samp_q;
            logic                      filt_q, prev_q, hold_q;
            logic               [15:0] capt_q;
            wire [1:0] cfg = evc[i][EV_CFG_LSB +: 2];
            wire [3:0] m   = mode[i][3:0];
            // filter sees the live input plus three stored samples
            wire all1 = ev_in[i] & (&samp_q);
            wire all0 = ~ev_in[i] & ~(|samp_q);
            wire lvl  = (cfg == CFG_FILTER) ? filt_q :
                        (cfg == CFG_ASYNC)  ? ev_in[i] : samp_q[0];
            wire cfg_ok  = (cfg == CFG_NEITHER) | (cfg == CFG_FILTER) | (cfg == CFG_ASYNC);
            wire act_lvl = evc[i][EV_TRIG] & cfg_ok
                         & (evc[i][EV_EDGE] ? lvl : ~lvl);
            wire edge_hit = act_lvl & ~prev_q;
            wire set_hold = (m == MODE_LEVEL_KEEP) ? act_lvl :
                            (edge_hit & (m != MODE_NONE) & (m <= MODE_LEVEL_KEEP));
            logic rel;
            always_comb
            begin
                case (m)
                    MODE_EXEC_OPP_FAULT, MODE_ALL_KEEP_PERIOD,
                    MODE_DEAD_TIME_FAULT, MODE_LEVEL_KEEP:
                        rel = ~act_lvl;
                    MODE_JUMP_OPP_WAIT, MODE_EXEC_OPP_WAIT, MODE_ALL_NEXT_WAIT:
                        rel = cycle_end & ~act_lvl;
                    MODE_EDGE_NEXT, MODE_EDGE_KEEP:
                        rel = cycle_end;
                    MODE_ALL_WAIT_SW:
                        rel = restart;
                    default:
                        rel = 1'b1;
                endcase
            end
            assign hit[i]      = edge_hit;
            assign own_stop[i] = hold_q & ((m < MODE_ALL_KEEP_PERIOD) | (m > MODE_ALL_WAIT_SW));
            assign all_stop[i] = hold_q & ~own_stop[i];
            assign jump[i]     = edge_hit & ((m == MODE_JUMP_OPP_WAIT) |
                                 (m == MODE_ALL_NEXT_WAIT) | (m == MODE_EDGE_NEXT));
            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    samp_q <= '0;
                    filt_q <= 1'b0;
                    prev_q <= 1'b0;
                    hold_q <= 1'b0;
                    capt_q <= 16'h0000;
                end
                else
                begin
                    samp_q <= {samp_q[FILTER_SAMPLES-3:0], ev_in[i]};
                    if (all1)
                        filt_q <= 1'b1;
                    else if (all0)
                        filt_q <= 1'b0;
                    prev_q <= act_lvl;
                    hold_q <= set_hold | (hold_q & ~rel);
                    if ((edge_hit & evc[i][EV_ACTION]) | trig_set[i] & ~edge_hit)
                        capt_q <= cnt_q;
                end
            end
        end
    endgenerate
    assign capture_a = g_in[0].capt_q;
    assign capture_b = g_in[1].capt_q;

    // outputs and sticky status
    wire stop_a = own_stop[0] | (|all_stop);
    wire stop_b = own_stop[1] | (|all_stop);
    wire wave_a_d = stop_a ? (fault_q[FC_EN_A] & fault_q[FC_VAL_A]) : base_a;
    wire wave_b_d = stop_b ? (fault_q[FC_EN_B] & fault_q[FC_VAL_B]) : base_b;
    wire [1:0] act_set = {wave_b_d ^ wave_out_b, wave_a_d ^ wave_out_a};
    wire [1:0] act_clr = wr_at(wr, idx, IDX_STATUS) ? {wd[ST_ACT_B], wd[ST_ACT_A]} : 2'b00;

    logic [7:0] flag_set, flag_clr, flags_d;
    always_comb
    begin
        flag_set = 8'h00;
        flag_set[IRQ_CYCLE_END] = cycle_end | restart;
        flag_set[IRQ_TRIG_A]    = trig_set[0];
        flag_set[IRQ_TRIG_B]    = trig_set[1];
        flag_clr = wr_at(wr, idx, IDX_INT_FLAGS) ? wd : 8'h00;
        // a set in the clearing cycle survives
        flags_d  = ((flags_q & ~flag_clr) | flag_set) & INT_MASK;
    end

    logic [7:0] rd;
    always_comb
    begin
        case (idx)
            IDX_CONTROL_A: rd = {7'h00, ctrl_en_q};
            IDX_CONTROL_C: rd = {6'h00, auto_upd_q, 1'b0};
            IDX_EVENT_A:   rd = ev_a_q;
            IDX_EVENT_B:   rd = ev_b_q;
            IDX_INT_EN:    rd = int_en_q;
            IDX_INT_FLAGS: rd = flags_q;
            IDX_STATUS:    rd = {act_q, 4'h0, cmd_ready_q, en_ready_q};
            IDX_INPUT_A:   rd = mode_a_q;
            IDX_INPUT_B:   rd = mode_b_q;
            IDX_FAULT:     rd = fault_q;
            IDX_DEBUG:     rd = {7'h00, debug_run_q};
            default:       rd = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ack_q    <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_q    <= req & ~ack_q;
            wb_dat_o <= {24'h00_0000, rd};
        end
    end
    assign wb_ack_o = ack_q;

    // software registers
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ev_a_q      <= REG_RESET;
            ev_b_q      <= REG_RESET;
            int_en_q    <= REG_RESET;
            mode_a_q    <= REG_RESET;
            mode_b_q    <= REG_RESET;
            fault_q     <= REG_RESET;
            auto_upd_q  <= 1'b0;
            debug_run_q <= 1'b0;
        end
        else
        begin
            if (wr_at(wr, idx, IDX_EVENT_A))   ev_a_q   <= wd & EV_MASK;
            if (wr_at(wr, idx, IDX_EVENT_B))   ev_b_q   <= wd & EV_MASK;
            if (wr_at(wr, idx, IDX_INT_EN))    int_en_q <= wd & INT_MASK;
            if (wr_at(wr, idx, IDX_INPUT_A))   mode_a_q <= wd & MODE_MASK;
            if (wr_at(wr, idx, IDX_INPUT_B))   mode_b_q <= wd & MODE_MASK;
            if (wr_at(wr, idx, IDX_FAULT))     fault_q  <= wd & FAULT_MASK;
            if (wr_at(wr, idx, IDX_CONTROL_C)) auto_upd_q  <= wd[CTRLC_AUTOUPD];
            if (wr_at(wr, idx, IDX_DEBUG))     debug_run_q <= wd[DEBUG_RUN];
        end
    end

    // command path; pipeline starts with one token in its first stage so ready rises shortly after reset
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cmd_pipe_q  <= {{(SYNC_STAGES-1){1'b0}}, 1'b1};
            cmd_bits_q  <= 5'h00;
            cmd_ready_q <= 1'b0;
            eoc_wait_q  <= 1'b0;
        end
        else
        begin
            cmd_pipe_q <= {cmd_pipe_q[SYNC_STAGES-2:0], cmd_start};
            if (cmd_start)
            begin
                cmd_ready_q <= 1'b0;
                cmd_bits_q  <= wr_cmd ? wd[4:0] : 5'h01;
            end
            else if (cmd_land & cmd_bits_q[CMD_SYNC_EOC])
                eoc_wait_q  <= 1'b1;
            else if (cmd_land)
                cmd_ready_q <= 1'b1;
            else if (eoc_wait_q & (cycle_end | ~run))
            begin
                eoc_wait_q  <= 1'b0;
                cmd_ready_q <= 1'b1;
            end
        end
    end

    // enable path; a write during sync or break is dropped
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            en_pipe_q  <= {{(SYNC_STAGES-1){1'b0}}, 1'b1};
            ctrl_en_q  <= 1'b0;
            en_val_q   <= 1'b0;
            en_dis_q   <= 1'b0;
            en_ready_q <= 1'b0;
            dis_wait_q <= 1'b0;
            timer_en_q <= 1'b0;
            brk_q      <= 1'b0;
        end
        else
        begin
            brk_q     <= brk;
            en_pipe_q <= {en_pipe_q[SYNC_STAGES-2:0], en_start | (brk_q & ~brk)};
            if (en_start)
            begin
                en_dis_q <= ~wr_control_a;
                if (wr_control_a)
                begin
                    ctrl_en_q <= wd[CONTROL_A_ENABLE];
                    en_val_q  <= wd[CONTROL_A_ENABLE];
                end
            end
            if (brk)
                en_ready_q <= 1'b0;
            else if (en_start)
                en_ready_q <= 1'b0;
            else if (en_land & en_dis_q)
                dis_wait_q <= 1'b1;
            else if (en_land)
            begin
                timer_en_q <= en_val_q;
                en_ready_q <= 1'b1;
            end
            else if (dis_wait_q & (cycle_end | ~run))
            begin
                dis_wait_q <= 1'b0;
                timer_en_q <= 1'b0;
                ctrl_en_q  <= 1'b0;
                // stale disable flag would switch the timer off on a later break resync
                en_dis_q   <= 1'b0;
                en_val_q   <= 1'b0;
                en_ready_q <= 1'b1;
            end
        end
    end

    // counter, waveforms, status and interrupt request
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cnt_q      <= 16'h0000;
            wave_out_a <= 1'b0;
            wave_out_b <= 1'b0;
            act_q      <= 2'b00;
            flags_q    <= REG_RESET;
            irq_out    <= 1'b0;
        end
        else
        begin
            if (restart | (|jump) | cycle_end)
                cnt_q <= 16'h0000;
            else if (run)
                cnt_q <= cnt_q + 16'h0001;
            wave_out_a <= wave_a_d;
            wave_out_b <= wave_b_d;
            act_q      <= (act_q & ~act_clr) | act_set;
            flags_q    <= flags_d;
            irq_out    <= |(flags_d & int_en_q);
        end
    end
endmodule
`default_nettype wire

// >>> pwmt_event_fault_sva.sv
`timescale 1ns/10ps
`default_nettype none
module pwmt_event_fault_chk
    import pwmt_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    wire logic       wr_en = wb_ack_o && wb_we_i && wb_sel_i[0];
    wire logic       rd_en = wb_ack_o && !wb_we_i;
    wire logic [5:0] idx   = wb_adr_i[7:2];
    logic [7:0]      en_q;
    // shadow of the enables, so an irq rise can be tied to its cause
    always_ff @(posedge core_clk)
    begin
        if (reset)
            en_q <= 8'h00;
        else if (wr_en && idx == IDX_INT_EN)
            en_q <= wb_dat_i[7:0] & INT_MASK;
    end
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    strobe_read_a: assert property (rd_en && idx == IDX_COMMAND |-> wb_dat_o == 32'h0)
        else $error("command strobes read nonzero");
    status_gap_a: assert property (rd_en && idx == IDX_STATUS |-> wb_dat_o[5:2] == 4'h0)
        else $error("status unused bits set");
    unmapped_zero_a: assert property (rd_en && idx == 6'h3F |-> wb_dat_o == 32'h0)
        else $error("unmapped read nonzero");
    irq_mask_a: assert property (wr_en && idx == IDX_INT_EN && wb_dat_i[7:0] == 8'h00
        |-> ##2 !irq_out) else $error("irq not masked");
    irq_cause_a: assert property ($rose(irq_out) |-> $past(en_q) != 8'h00)
        else $error("irq without enable");
    flag_keep_a: assert property (wr_en && idx == IDX_INT_FLAGS && wb_dat_i[7:0] == 8'h00
        && irq_out |=> irq_out [*2]) else $error("zero write cleared flag");
endmodule
bind pwmt_event_fault pwmt_event_fault_chk u_chk (.core_clk(core_clk), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_out(irq_out));
`default_nettype wire

// >>> pwmt_event_fault_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pwmt_event_fault_tb
    import pwmt_pkg::*;
;
    localparam logic [5:0] RW_IDX [5] = '{IDX_EVENT_A, IDX_EVENT_B, IDX_INT_EN, IDX_INPUT_A,
        IDX_INPUT_B};
    localparam logic [7:0] RW_MSK [5] = '{EV_MASK, EV_MASK, INT_MASK, MODE_MASK, MODE_MASK};
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic        debug_break = 1'b0;
    logic [1:0]  ev_idle  = 2'h0;
    logic [1:0]  ev_go    = 2'h0;
    logic [3:0]  ev_len   = 4'h0;
    logic [1:0]  ev_line, ev_busy;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, wave_out_a, wave_out_b, irq_out;
    logic [15:0] capture_a, capture_b;
    logic [31:0] exp_q[$];
    int          miscompares = 0;
    int          tests_run   = 0;
    int          seed        = 32'h28BE;
    always #4 core_clk = ~core_clk;
    pwmt_event_fault #(.PERIOD(16'h0010)) dut (.core_clk(core_clk), .reset(reset),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .event_a_in(ev_line[0]), .event_b_in(ev_line[1]), .debug_break(debug_break),
        .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .irq_out(irq_out),
        .capture_a(capture_a), .capture_b(capture_b));
    for (genvar i = 0; i < 2; i++)
    begin : g_src
        pwmt_event_src u_src (.core_clk(core_clk), .idle_level(ev_idle[i]),
            .pulse_go(ev_go[i]), .pulse_len(ev_len), .event_out(ev_line[i]),
            .busy(ev_busy[i]));
    end
    task automatic check_val(input logic [31:0] seen, input logic [31:0] expv);
        tests_run++;
        if (seen !== expv)
        begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic print_verdict;
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic bus(input logic [5:0] idx, input logic wr, input logic [7:0] d);
        int n = 0;
        wb_adr_i <= {idx, 2'b00};
        wb_we_i  <= wr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h0, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1)
        begin
            miscompares++;
            print_verdict();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask
    task automatic rd(input logic [5:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(idx, 1'b0, 8'h00);
    endtask
    task automatic pulse(input int ch, input logic [3:0] len);
        int n = 0;
        ev_len    <= len;
        ev_go[ch] <= 1'b1;
        @(posedge core_clk);
        ev_go[ch] <= 1'b0;
        do
            @(posedge core_clk);
        while (ev_busy[ch] === 1'b1 && n++ < 20);
        if (ev_busy[ch] === 1'b1)
        begin
            miscompares++;
            print_verdict();
        end
        repeat (10) @(posedge core_clk);
    endtask
    // read data is taken at the rising edge where ack is sampled high
    always @(posedge core_clk)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            check_val(wb_dat_o, exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEADBEEF);
    initial
    begin
        logic [7:0] v;
        logic [1:0] c;
        logic       t;
        logic       hit;
        int         ch;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        for (int i = 0; i < 5; i++)
            rd(RW_IDX[i], 8'h00);
        rd(IDX_INT_FLAGS, 8'h00);
        rd(IDX_STATUS, 8'h03);
        wr(6'h3F, 8'hFF);
        rd(6'h3F, 8'h00);
        rd(IDX_COMMAND, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            v = 8'($random(seed));
            wr(RW_IDX[i], v);
            rd(RW_IDX[i], v & RW_MSK[i]);
        end
        for (int m = 0; m <= 10; m++)
        begin
            wr(IDX_INPUT_A, 8'(m));
            wr(IDX_INPUT_B, 8'(10 - m));
            rd(IDX_INPUT_A, 8'(m));
            rd(IDX_INPUT_B, 8'(10 - m));
        end
        wr(IDX_INPUT_A, 8'h00);
        wr(IDX_INPUT_B, 8'h00);
        wr(IDX_INT_EN, 8'h0C);
        for (int k = 0; k < 32; k++)
        begin
            ch = k % 2;
            c  = k[4:3];
            t  = 1'($random(seed));
            ev_idle[ch] <= !k[1];
            wr(ch ? IDX_EVENT_B : IDX_EVENT_A, {c, 1'b0, k[1], 1'b0, k[2], 1'b0, t});
            repeat (8) @(posedge core_clk);
            wr(IDX_INT_FLAGS, 8'h0D);
            pulse(ch, k[2] ? 4'h8 : 4'h2);
            // filter swallows the short glitch, reserved cfg ignores the line
            hit = t && c != 2'h3 && (c != CFG_FILTER || k[2]);
            rd(IDX_INT_FLAGS, hit ? (ch ? 8'h08 : 8'h04) : 8'h00);
            check_val({31'h0, irq_out}, {31'h0, hit});
        end
        ev_idle <= 2'h0;
        wr(IDX_EVENT_A, 8'h15);
        wr(IDX_EVENT_B, 8'h00);
        repeat (8) @(posedge core_clk);
        wr(IDX_INT_FLAGS, 8'h0D);
        pulse(0, 4'h4);
        wr(IDX_INT_FLAGS, 8'h00);
        rd(IDX_INT_FLAGS, 8'h04);
        wr(IDX_INT_EN, 8'h00);
        @(posedge core_clk);
        check_val({31'h0, irq_out}, 32'h0);
        wr(IDX_INT_FLAGS, 8'h04);
        rd(IDX_INT_FLAGS, 8'h00);
        wr(IDX_INT_EN, 8'h01);
        wr(IDX_CONTROL_A, 8'h01);
        repeat (40) @(posedge core_clk);
        rd(IDX_INT_FLAGS, 8'h01);
        check_val({31'h0, irq_out}, 32'h1);
        rd(IDX_STATUS, 8'hC3);
        wr(IDX_FAULT, 8'h33);
        wr(IDX_INPUT_A, {4'h0, MODE_ALL_WAIT_SW});
        pulse(0, 4'h4);
        check_val({30'h0, wave_out_b, wave_out_a}, 32'h3);
        wr(IDX_STATUS, 8'hC0);
        rd(IDX_STATUS, 8'h03);
        wr(IDX_COMMAND, 8'h04);
        wr(IDX_INPUT_A, 8'h00);
        repeat (40) @(posedge core_clk);
        rd(IDX_STATUS, 8'hC3);
        wr(IDX_COMMAND, 8'h80);
        repeat (40) @(posedge core_clk);
        check_val({30'h0, wave_out_b, wave_out_a}, 32'h0);
        wr(IDX_STATUS, 8'hC0);
        wr(IDX_INT_FLAGS, 8'h0D);
        rd(IDX_INT_FLAGS, 8'h00);
        wr(IDX_COMMAND, 8'h08);
        rd(IDX_STATUS, 8'h01);
        rd(IDX_INT_FLAGS, 8'h04);
        check_val({16'h0, capture_a}, 32'h0);
        wr(IDX_CONTROL_C, 8'h02);
        wr(IDX_CMPB_CLRH, 8'h00);
        rd(IDX_STATUS, 8'h01);
        wr(IDX_COMMAND, 8'h10);
        repeat (4) @(posedge core_clk);
        rd(IDX_INT_FLAGS, 8'h0C);
        check_val({16'h0, capture_b}, 32'h0);
        debug_break <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(IDX_STATUS, 8'h02);
        debug_break <= 1'b0;
        repeat (6) @(posedge core_clk);
        rd(IDX_STATUS, 8'h03);
        wr(IDX_DEBUG, 8'h01);
        debug_break <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(IDX_STATUS, 8'h03);
        debug_break <= 1'b0;
        check_val(32'(exp_q.size()), 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> pwmt_event_src.sv
`timescale 1ns/10ps
`default_nettype none
module pwmt_event_src (
    input  wire logic       core_clk,
    input  wire logic       idle_level,
    input  wire logic       pulse_go,
    input  wire logic [3:0] pulse_len,
    output logic            event_out,
    output logic            busy
);
    logic [3:0] left_q = 4'h0;
    // event channel is clocked by core_clk, so the line moves only on edges
    always_ff @(posedge core_clk)
    begin
        if (pulse_go && left_q == 4'h0)
            left_q <= pulse_len;
        else if (left_q != 4'h0)
            left_q <= left_q - 4'h1;
    end
    assign event_out = (left_q != 4'h0) ? !idle_level : idle_level;
    assign busy      = left_q != 4'h0;
endmodule
`default_nettype wire

// >>> pwmt_pkg.sv
`default_nettype none
package pwmt_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_CONTROL_A = 6'h00;
    localparam logic [5:0] IDX_CONTROL_C = 6'h02;
    localparam logic [5:0] IDX_COMMAND   = 6'h04;
    localparam logic [5:0] IDX_EVENT_A   = 6'h08;
    localparam logic [5:0] IDX_EVENT_B   = 6'h09;
    localparam logic [5:0] IDX_INT_EN    = 6'h0C;
    localparam logic [5:0] IDX_INT_FLAGS = 6'h0D;
    localparam logic [5:0] IDX_STATUS    = 6'h0E;
    localparam logic [5:0] IDX_INPUT_A   = 6'h10;
    localparam logic [5:0] IDX_INPUT_B   = 6'h11;
    localparam logic [5:0] IDX_FAULT     = 6'h12;
    localparam logic [5:0] IDX_DEBUG     = 6'h1E;
    localparam logic [5:0] IDX_CMPB_CLRH = 6'h2F;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] EV_MASK    = 8'hD5;
    localparam logic [7:0] INT_MASK   = 8'h0D;
    localparam logic [7:0] MODE_MASK  = 8'h0F;
    localparam logic [7:0] FAULT_MASK = 8'h33;

    localparam int CONTROL_A_ENABLE  = 0;
    localparam int CTRLC_AUTOUPD = 1;
    localparam int CMD_SYNC_EOC  = 0;
    localparam int CMD_SYNC      = 1;
    localparam int CMD_RESTART   = 2;
    localparam int CMD_CAPT_A    = 3;
    localparam int CMD_CAPT_B    = 4;
    localparam int CMD_DIS_EOC   = 7;
    localparam int EV_TRIG       = 0;
    localparam int EV_ACTION     = 2;
    localparam int EV_EDGE       = 4;
    localparam int EV_CFG_LSB    = 6;
    localparam int IRQ_CYCLE_END = 0;
    localparam int IRQ_TRIG_A    = 2;
    localparam int IRQ_TRIG_B    = 3;
    localparam int ST_EN_READY   = 0;
    localparam int ST_CMD_READY  = 1;
    localparam int ST_ACT_A      = 6;
    localparam int ST_ACT_B      = 7;
    localparam int FC_VAL_A      = 0;
    localparam int FC_VAL_B      = 1;
    localparam int FC_EN_A       = 4;
    localparam int FC_EN_B       = 5;
    localparam int DEBUG_RUN     = 0;

    localparam logic [1:0] CFG_NEITHER = 2'h0;
    localparam logic [1:0] CFG_FILTER  = 2'h1;
    localparam logic [1:0] CFG_ASYNC   = 2'h2;

    localparam logic [3:0] MODE_NONE            = 4'h0;
    localparam logic [3:0] MODE_JUMP_OPP_WAIT   = 4'h1;
    localparam logic [3:0] MODE_EXEC_OPP_WAIT   = 4'h2;
    localparam logic [3:0] MODE_EXEC_OPP_FAULT  = 4'h3;
    localparam logic [3:0] MODE_ALL_KEEP_PERIOD = 4'h4;
    localparam logic [3:0] MODE_DEAD_TIME_FAULT = 4'h5;
    localparam logic [3:0] MODE_ALL_NEXT_WAIT   = 4'h6;
    localparam logic [3:0] MODE_ALL_WAIT_SW     = 4'h7;
    localparam logic [3:0] MODE_EDGE_NEXT       = 4'h8;
    localparam logic [3:0] MODE_EDGE_KEEP       = 4'h9;
    localparam logic [3:0] MODE_LEVEL_KEEP      = 4'hA;

    localparam int FILTER_SAMPLES = 4;
    localparam int SYNC_STAGES    = 2;
endpackage
`default_nettype wire

// >>> pwmt_unused_marker.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire
